// File: logic/hpbd_core.sv
// Functional notes
// - Doorbell rising edge gives one CPU pulse
// - CPU write of one acknowledges doorbell
// - No pulse while doorbell already set
// - Zero writes ignored; reset clears doorbell
// - CPU write of one drops host interrupt
// - Host write of one releases host interrupt
// - Zero writes ignored; reset releases interrupt
// - Separate eight-word read and write FIFOs
// - Read address write flushes after fill
// - No reads after flush until triggered
// - First incrementing read fills two bursts
// - Refill burst whenever four slots free
// - Fetch bit is a command, not stored
// - Fixed read flushes, reads once, stops
// - Write address write drains write FIFO
// - Posted writes burst in fours
// - Full write FIFO holds host off
// - Time-out drains short write tail
// - Fixed write flushes, writes once, stops
// - Host held off during any flush
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "hpbd_map.svh"

module hpbd_core #(
    parameter int DEPTH   = `HPBD_FIFO_DEPTH,
    parameter int TMO_CLK = `HPBD_WR_TMO_CLKS
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Host port
    input  wire logic        cycle_type_sel_hi,
    input  wire logic        cycle_type_sel_lo,
    input  wire logic        host_aw_sel,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [31:0] host_wdata,
    output logic      [31:0] host_rdata,
    output logic             host_ready_n,
    output logic             host_int_n,
    // CPU side
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [31:0] cpu_wdata,
    output logic      [31:0] cpu_rdata,
    output logic             cpu_irq_pulse,
    // Memory DMA master
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [2:0]  mem_len,
    output logic      [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int TW = hpbd_pkg::HPBD_TMO_W;
    localparam logic [CW-1:0] BURST = CW'(`HPBD_BURST_WORDS);
    localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CLK - 1);
    localparam logic [31:0] STEP = 32'(`HPBD_WORD_BYTES);

    typedef struct packed {
        hpbd_pkg::hpbd_dma_t st;
        logic [2:0]          beats;
        logic [2:0]          dma_len;
        logic                dma_single;
        logic [31:0]         dma_addr;
        logic [31:0]         rd_addr;
        logic [31:0]         wr_addr;
        logic                pf_on;
        logic                single_pend;
        logic                rd_flush_pend;
        logic                rd_wait;
        logic                fixed_word;
        logic                wr_flush;
        logic                burst_en;
        logic [TW-1:0]       tmo;
        logic [31:0]         host_rdata;
        logic [31:0]         cpu_rdata;
    } hpbd_core_st_t;

    hpbd_core_st_t s;
    hpbd_core_st_t next_s;

    hpbd_pkg::hpbd_cyc_t cyc;
    logic                rd_push;
    logic                rd_pop;
    logic                rd_flush;
    logic                wr_push;
    logic                wr_pop;
    logic [31:0]         rd_head;
    logic [31:0]         wr_head;
    logic [CW-1:0]       rd_count;
    logic [CW-1:0]       wr_count;
    logic                rd_empty;
    logic                wr_empty;
    logic                wr_full;
    logic                tmo_run;
    logic                h2c_set;
    logic                h2c_clr;
    logic                c2h_set;
    logic                c2h_clr;
    logic                h2c_flag;
    logic                c2h_flag;
    logic [31:0]         ctl_word;

    ////////////////////////////////////////////////////////////////////
    // Doorbells

    assign cyc = hpbd_pkg::hpbd_cyc_t'({cycle_type_sel_hi, cycle_type_sel_lo});

    assign h2c_set = host_wr && cyc == hpbd_pkg::HPBD_CYC_CTL
                     && host_wdata[`HPBD_CTL_H2C_BIT];
    assign h2c_clr = cpu_wr && cpu_wdata[`HPBD_CTL_H2C_BIT];
    assign c2h_set = cpu_wr && cpu_wdata[`HPBD_CTL_C2H_BIT];
    assign c2h_clr = host_wr && cyc == hpbd_pkg::HPBD_CYC_CTL
                     && host_wdata[`HPBD_CTL_C2H_BIT];

    hpbd_doorbell u_h2c (
        .mclk   (mclk),
        .arst_n (arst_n),
        .set_wr (h2c_set),
        .clr_wr (h2c_clr),
        .flag   (h2c_flag),
        .rise   (cpu_irq_pulse)
    );

    hpbd_doorbell u_c2h (
        .mclk   (mclk),
        .arst_n (arst_n),
        .set_wr (c2h_set),
        .clr_wr (c2h_clr),
        .flag   (c2h_flag),
        .rise   ()
    );

    assign host_int_n = ~c2h_flag;

    ////////////////////////////////////////////////////////////////////
    // FIFOs

    hpbd_fifo #(.W(32), .DEPTH(DEPTH)) u_rd_fifo (
        .mclk   (mclk),
        .arst_n (arst_n),
        .push   (rd_push),
        .wdata  (mem_rdata),
        .pop    (rd_pop),
        .head   (rd_head),
        .flush  (rd_flush),
        .count  (rd_count),
        .empty  (rd_empty),
        .full   ()
    );

    hpbd_fifo #(.W(32), .DEPTH(DEPTH)) u_wr_fifo (
        .mclk   (mclk),
        .arst_n (arst_n),
        .push   (wr_push),
        .wdata  (host_wdata),
        .pop    (wr_pop),
        .head   (wr_head),
        .flush  (1'b0),
        .count  (wr_count),
        .empty  (wr_empty),
        .full   (wr_full)
    );

    // Held off on any flush, a full write FIFO or a read still waiting
    assign host_ready_n = s.rd_flush_pend | s.single_pend | s.wr_flush
                          | wr_full | (s.rd_wait & rd_empty);

    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[`HPBD_CTL_H2C_BIT] = h2c_flag;
        ctl_word[`HPBD_CTL_C2H_BIT] = c2h_flag;
        ctl_word[`HPBD_CTL_READY_BIT] = ~host_ready_n;
    end

    ////////////////////////////////////////////////////////////////////
    // DMA and host data path

    assign tmo_run = s.burst_en && !wr_empty && wr_count < BURST
                     && !s.wr_flush && s.st != hpbd_pkg::HPBD_DMA_WR;

    always_comb begin
        logic [2:0] wlen;
        wlen = (wr_count < BURST) ? wr_count[2:0] : 3'(`HPBD_BURST_WORDS);
        next_s = s;
        rd_push = 1'b0;
        rd_pop = 1'b0;
        rd_flush = 1'b0;
        wr_push = 1'b0;
        wr_pop = 1'b0;
        // One beat per acknowledge
        if (s.st != hpbd_pkg::HPBD_DMA_IDLE && mem_ack) begin
            next_s.dma_addr = s.dma_addr + STEP;
            next_s.beats = s.beats - 3'd1;
            if (s.st == hpbd_pkg::HPBD_DMA_RD) begin
                rd_push = 1'b1;
            end else begin
                wr_pop = 1'b1;
            end
            if (s.beats == 3'd1) begin
                next_s.st = hpbd_pkg::HPBD_DMA_IDLE;
                next_s.fixed_word = s.dma_single;
            end
        end
        // A fill in flight lands first, then the pointers reset
        if (s.rd_flush_pend && s.st != hpbd_pkg::HPBD_DMA_RD) begin
            rd_flush = 1'b1;
            next_s.rd_flush_pend = 1'b0;
            next_s.fixed_word = 1'b0;
        end
        if (s.wr_flush && wr_empty && s.st != hpbd_pkg::HPBD_DMA_WR) begin
            next_s.wr_flush = 1'b0;
        end
        if (tmo_run) begin
            next_s.tmo = s.tmo + TW'(1);
            if (s.tmo == TMO_LAST) begin
                next_s.wr_flush = 1'b1;
            end
        end else begin
            next_s.tmo = '0;
        end
        if (s.rd_wait && !rd_empty && !s.rd_flush_pend && !s.single_pend) begin
            next_s.rd_wait = 1'b0;
        end
        // Burst start, single reads first, then writes, then prefetch
        if (s.st == hpbd_pkg::HPBD_DMA_IDLE) begin
            if (s.single_pend && !s.rd_flush_pend) begin
                next_s.st = hpbd_pkg::HPBD_DMA_RD;
                next_s.beats = 3'd1;
                next_s.dma_len = 3'd1;
                next_s.dma_single = 1'b1;
                next_s.dma_addr = s.rd_addr;
                next_s.single_pend = 1'b0;
            end else if (!wr_empty && (s.wr_flush
                         || (s.burst_en && wr_count >= BURST))) begin
                next_s.st = hpbd_pkg::HPBD_DMA_WR;
                next_s.beats = wlen;
                next_s.dma_len = wlen;
                next_s.dma_single = 1'b0;
                next_s.dma_addr = s.wr_addr;
                next_s.wr_addr = s.wr_addr + {27'h000_0000, wlen, 2'b00};
            end else if (s.pf_on && !s.rd_flush_pend
                         && rd_count <= CW'(DEPTH) - BURST) begin
                next_s.st = hpbd_pkg::HPBD_DMA_RD;
                next_s.beats = 3'(`HPBD_BURST_WORDS);
                next_s.dma_len = 3'(`HPBD_BURST_WORDS);
                next_s.dma_single = 1'b0;
                next_s.dma_addr = s.rd_addr;
                next_s.rd_addr = s.rd_addr + STEP * 32'(`HPBD_BURST_WORDS);
            end
        end
        // Host writes
        if (host_wr) begin
            unique case (cyc)
                hpbd_pkg::HPBD_CYC_CTL: begin
                    if (host_wdata[`HPBD_CTL_FETCH_BIT]) begin
                        next_s.pf_on = 1'b1;
                    end
                end
                hpbd_pkg::HPBD_CYC_ADDR: begin
                    if (!host_aw_sel) begin
                        next_s.rd_addr = host_wdata;
                        next_s.rd_flush_pend = 1'b1;
                        next_s.pf_on = 1'b0;
                        next_s.single_pend = 1'b0;
                    end else if (wr_empty && !s.wr_flush
                                 && s.st != hpbd_pkg::HPBD_DMA_WR) begin
                        next_s.wr_addr = host_wdata;
                    end else begin
                        // Refused: posted words go out to the old address
                        next_s.wr_flush = 1'b1;
                    end
                end
                hpbd_pkg::HPBD_CYC_DATA_INC: begin
                    if (!wr_full && !s.wr_flush) begin
                        wr_push = 1'b1;
                        next_s.burst_en = 1'b1;
                        next_s.tmo = '0;
                    end
                end
                hpbd_pkg::HPBD_CYC_DATA_FIX: begin
                    if (!wr_full && !s.wr_flush) begin
                        wr_push = 1'b1;
                        next_s.burst_en = 1'b0;
                        next_s.wr_flush = 1'b1;
                        next_s.tmo = '0;
                    end
                end
            endcase
        end
        // Host reads
        if (host_rd) begin
            unique case (cyc)
                hpbd_pkg::HPBD_CYC_CTL: begin
                    next_s.host_rdata = ctl_word;
                end
                hpbd_pkg::HPBD_CYC_ADDR: begin
                    next_s.host_rdata = host_aw_sel ? s.wr_addr : s.rd_addr;
                end
                hpbd_pkg::HPBD_CYC_DATA_INC: begin
                    next_s.pf_on = 1'b1;
                    if (!rd_empty && !s.rd_flush_pend && !s.single_pend) begin
                        rd_pop = 1'b1;
                        next_s.host_rdata = rd_head;
                        next_s.fixed_word = 1'b0;
                    end else begin
                        next_s.rd_wait = 1'b1;
                    end
                end
                hpbd_pkg::HPBD_CYC_DATA_FIX: begin
                    if (s.fixed_word && !rd_empty) begin
                        rd_pop = 1'b1;
                        next_s.host_rdata = rd_head;
                        next_s.fixed_word = 1'b0;
                    end else begin
                        next_s.rd_flush_pend = 1'b1;
                        next_s.single_pend = 1'b1;
                        next_s.pf_on = 1'b0;
                        next_s.rd_wait = 1'b1;
                    end
                end
            endcase
        end
        if (cpu_rd) begin
            next_s.cpu_rdata = ctl_word;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign host_rdata = s.host_rdata;
    assign cpu_rdata  = s.cpu_rdata;
    assign mem_req    = (s.st != hpbd_pkg::HPBD_DMA_IDLE);
    assign mem_we     = (s.st == hpbd_pkg::HPBD_DMA_WR);
    assign mem_addr   = s.dma_addr;
    assign mem_len    = s.dma_len;
    assign mem_wdata  = wr_head;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    chk_h2c_pulse_edge: assert property (
        $rose(h2c_flag) |-> cpu_irq_pulse && $past(h2c_set))
        else $error("doorbell rose without a single pulse");

    chk_h2c_no_repeat: assert property (
        h2c_flag |=> !cpu_irq_pulse)
        else $error("pulse issued while doorbell set");

    chk_h2c_cpu_ack: assert property (
        h2c_clr && !h2c_set |=> !h2c_flag)
        else $error("cpu acknowledge did not clear doorbell");

    chk_c2h_drive_low: assert property (
        c2h_set |=> !host_int_n)
        else $error("host interrupt not driven low");

    chk_c2h_host_ack: assert property (
        c2h_clr && !c2h_set |=> host_int_n)
        else $error("host acknowledge did not release interrupt");

    chk_wr_full_hold: assert property (
        wr_full |-> host_ready_n)
        else $error("ready shown with write FIFO full");

    chk_flush_hold: assert property (
        (s.wr_flush || s.rd_flush_pend) |-> host_ready_n)
        else $error("ready shown during a flush");

    chk_rd_flush_wait: assert property (
        rd_flush |-> s.st != hpbd_pkg::HPBD_DMA_RD ##1 rd_empty)
        else $error("read FIFO flushed during a fill");

    chk_wr_burst_four: assert property (
        $rose(mem_we) && !$past(s.wr_flush) |-> mem_len == 3'd4 && $past(wr_count) >= 4)
        else $error("posted write burst not four words");

    chk_tmo_expire: assert property (
        tmo_run && s.tmo == TMO_LAST && !wr_push |=> s.wr_flush)
        else $error("write time-out did not start a drain");

    chk_tmo_idle: assert property (
        (wr_empty || wr_count >= BURST) |=> s.tmo == '0)
        else $error("time-out ran outside one to three words");

    chk_fix_rd_single: assert property (
        $rose(mem_req) && !mem_we && s.dma_single |-> mem_len == 3'd1 && !s.pf_on)
        else $error("fixed read not a lone single word");

endmodule // hpbd_core

// File: logic/hpbd_map.svh
`ifndef HPBD_MAP_SVH
`define HPBD_MAP_SVH

// Control word bit positions
`define HPBD_CTL_H2C_BIT    1
`define HPBD_CTL_C2H_BIT    2
`define HPBD_CTL_READY_BIT  3
`define HPBD_CTL_FETCH_BIT  4

// FIFO geometry and DMA bursts
`define HPBD_FIFO_DEPTH     8
`define HPBD_WORD_W         32
`define HPBD_BURST_WORDS    4
`define HPBD_WORD_BYTES     4

// Write time-out, in mclk cycles
`define HPBD_WR_TMO_CLKS    256

// Reset values
`define HPBD_ADDR_RST       32'h0000_0000

`endif

// File: logic/hpbd_pkg.sv
`include "hpbd_map.svh"

package hpbd_pkg;

    typedef enum logic [1:0] {
        HPBD_CYC_CTL      = 2'b00,
        HPBD_CYC_DATA_INC = 2'b01,
        HPBD_CYC_ADDR     = 2'b10,
        HPBD_CYC_DATA_FIX = 2'b11
    } hpbd_cyc_t;

    typedef enum logic [1:0] {
        HPBD_DMA_IDLE = 2'b00,
        HPBD_DMA_RD   = 2'b01,
        HPBD_DMA_WR   = 2'b10
    } hpbd_dma_t;

    localparam int HPBD_TMO_W = $clog2(`HPBD_WR_TMO_CLKS);

endpackage

// File: logic/hpbd_fifo.sv
`timescale 1ns/10ps
`include "hpbd_map.svh"

module hpbd_fifo #(
    parameter int W     = `HPBD_WORD_W,
    parameter int DEPTH = `HPBD_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    // Write side
    input  wire logic                       push,
    input  wire logic [W-1:0]               wdata,
    // Read side
    input  wire logic                       pop,
    output logic      [W-1:0]               head,
    // Control and level
    input  wire logic                       flush,
    output logic      [$clog2(DEPTH):0]     count,
    output logic                            empty,
    output logic                            full
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             count;
        logic [W-1:0]            head;
    } hpbd_fifo_st_t;

    hpbd_fifo_st_t s;
    hpbd_fifo_st_t next_s;

    // Head is registered show-ahead; a push into the slot about to be
    // read bypasses the array so the head is never a stale word.
    always_comb begin
        logic [AW-1:0] nr;
        nr = s.rptr + AW'(pop);
        next_s = s;
        next_s.rptr = nr;
        if (push) begin
            next_s.mem[s.wptr] = wdata;
            next_s.wptr = s.wptr + AW'(1);
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
        next_s.head = (push && s.wptr == nr) ? wdata : s.mem[nr];
        if (flush) begin
            next_s.wptr = '0;
            next_s.rptr = '0;
            next_s.count = '0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign head  = s.head;
    assign count = s.count;
    assign empty = (s.count == '0);
    assign full  = (s.count == (AW+1)'(DEPTH));

endmodule // hpbd_fifo

// File: logic/hpbd_doorbell.sv
`timescale 1ns/10ps

module hpbd_doorbell (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // Writes of one from either party
    input  wire logic set_wr,
    input  wire logic clr_wr,
    // State
    output logic      flag,
    output logic      rise
);
    typedef struct packed {
        logic flag;
        logic rise;
    } hpbd_bell_st_t;

    hpbd_bell_st_t s;
    hpbd_bell_st_t next_s;

    // Set wins over a clear in the same cycle, so no ring is lost
    always_comb begin
        next_s = s;
        next_s.flag = set_wr | (s.flag & ~clr_wr);
        next_s.rise = set_wr & ~s.flag;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign flag = s.flag;
    assign rise = s.rise;

endmodule // hpbd_doorbell

// File: tb/hpbd_mem_model.sv
`timescale 1ns/10ps

module hpbd_mem_model #(
    parameter logic [31:0] KEY = 32'h5a5a_0000
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Burst port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [2:0]  mem_len,
    input  wire logic [31:0] mem_wdata,
    output logic      [31:0] mem_rdata,
    output logic             mem_ack,
    // Pacing and record
    input  wire logic        slow,
    output int               n_rb,
    output int               n_wb,
    output logic      [31:0] last_wdata,
    output logic      [2:0]  last_len
);
    int dly;
    int beats;

    ////////////////////////////////////////
    // Read data toggles outside a beat so a stale word never looks valid
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {mem_ack, mem_rdata, n_rb, n_wb, last_wdata, last_len, dly, beats} <= '0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            dly       <= dly + 1;
            if (!mem_req) begin
                {dly, beats} <= '0;
            end else if (!mem_ack && beats < int'(mem_len) && dly >= (slow ? 40 : 1)) begin
                mem_ack   <= 1'b1;
                dly       <= 0;
                beats     <= beats + 1;
                mem_rdata <= mem_addr ^ KEY;
                if (beats == 0) begin
                    last_len <= mem_len;
                    n_rb     <= n_rb + int'(!mem_we);
                end
                if (mem_we) begin
                    n_wb       <= n_wb + 1;
                    last_wdata <= mem_wdata;
                end
            end
        end
    end
endmodule // hpbd_mem_model

// File: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    localparam logic [31:0] KEY = 32'h5a5a_0000;
    localparam logic [31:0] RA  = 32'h0000_1000;
    localparam logic [31:0] WA  = 32'h0000_2000;
    typedef struct packed {
        logic        cpu;
        logic [31:0] d;
        logic        pulse;
        logic        h2c;
        logic        int_n;
    } hpbd_row_t;

    logic        mclk = 0, arst_n = 0, host_aw_sel = 0, host_wr = 0, host_rd = 0;
    logic        cycle_type_sel_hi = 0, cycle_type_sel_lo = 0, cpu_wr = 0, slow = 0;
    logic        cpu_rd = 0;
    logic [31:0] host_wdata = 0, cpu_wdata = 0, host_rdata, mem_addr, mem_wdata, mem_rdata;
    logic        host_ready_n, host_int_n, cpu_irq_pulse, mem_req, mem_we, mem_ack;
    logic [2:0]  mem_len, last_len;
    logic [31:0] last_wdata, cpu_rdata;
    int          n_rb, n_wb, n_errors = 0, total_checks = 0, cyc = 0, wn = 0;
    hpbd_row_t   rows [8] = '{
        '{0, 32'h0000_0002, 1, 1, 1}, '{0, 32'h0000_0002, 0, 1, 1},
        '{0, 32'h0000_0000, 0, 1, 1}, '{1, 32'h0000_0002, 0, 0, 1},
        '{0, 32'h0000_0002, 1, 1, 1}, '{1, 32'h0000_0004, 0, 1, 0},
        '{1, 32'h0000_0000, 0, 1, 0}, '{0, 32'h0000_0004, 0, 1, 1}};

    // Short time-out keeps the drain cases quick
    hpbd_core #(.TMO_CLK(8)) DUT (.mclk, .arst_n, .cycle_type_sel_hi, .cycle_type_sel_lo,
        .host_aw_sel, .host_wr, .host_rd, .host_wdata, .host_rdata, .host_ready_n,
        .host_int_n, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .cpu_irq_pulse, .mem_req,
        .mem_we, .mem_addr, .mem_len, .mem_wdata, .mem_rdata, .mem_ack);
    hpbd_mem_model #(.KEY(KEY)) mem (.mclk, .arst_n, .mem_req, .mem_we, .mem_addr, .mem_len,
        .mem_wdata, .mem_rdata, .mem_ack, .slow, .n_rb, .n_wb, .last_wdata, .last_len);

    ////////////////////////////////////////
    always #5 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish;
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Returns just after the sampling edge, where registered answers have landed
    task automatic hbus(input logic [1:0] t, input logic aw, input logic rd,
                        input logic [31:0] d);
        @(posedge mclk);
        {cycle_type_sel_hi, cycle_type_sel_lo} <= t;
        host_aw_sel <= aw;
        host_wr     <= !rd;
        host_rd     <= rd;
        host_wdata  <= d;
        @(posedge mclk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        #1;
    endtask

    task automatic cpu_bus(input logic rd, input logic [31:0] d);
        @(posedge mclk);
        cpu_wr    <= !rd;
        cpu_rd    <= rd;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        #1;
    endtask

    task automatic wait_rdy;
        for (int i = 0; i < 2000 && host_ready_n !== 1'b0; i++)
            @(posedge mclk);
        #1;
    endtask

    task automatic post(input int n);
        repeat (n) begin
            hbus(2'b01, 0, 0, 32'hd000_0000 + wn);
            wn++;
        end
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        #1;
        cmp(host_ready_n, 1'b0);
        cmp(host_int_n, 1'b1);
        cmp(mem_req, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].cpu)
                cpu_bus(0, rows[i].d);
            else
                hbus(2'b00, 0, 0, rows[i].d);
            cmp(cpu_irq_pulse, rows[i].pulse);
            cmp(host_int_n, rows[i].int_n);
            hbus(2'b00, 0, 1, 0);
            cmp(host_rdata[1], rows[i].h2c);
            cpu_bus(1, 0);
            cmp(cpu_rdata, {28'h000_0000, 1'b1, !rows[i].int_n, rows[i].h2c, 1'b0});
        end
        $display("test doorbells done");
        hbus(2'b10, 0, 0, RA);
        repeat (10) @(posedge mclk);
        cmp(n_rb, 0);
        hbus(2'b10, 0, 1, 0);
        cmp(host_rdata, RA);
        hbus(2'b01, 0, 1, 0);
        @(posedge mclk);
        #1;
        cmp(host_ready_n, 1'b1);
        for (int i = 0; i < 12; i++) begin
            if (i % 4 == 0) begin
                wait_rdy;
                repeat (40) @(posedge mclk);
            end
            hbus(2'b01, 0, 1, 0);
            cmp(host_rdata, (RA + 4 * i) ^ KEY);
        end
        repeat (40) @(posedge mclk);
        cmp(n_rb, 5);
        hbus(2'b10, 0, 0, RA + 32'h0000_0100);
        repeat (20) @(posedge mclk);
        cmp(n_rb, 5);
        hbus(2'b00, 0, 0, 32'h0000_0010);
        repeat (40) @(posedge mclk);
        cmp(n_rb, 7);
        hbus(2'b00, 0, 1, 0);
        cmp(host_rdata[4], 1'b0);
        hbus(2'b01, 0, 1, 0);
        cmp(host_rdata, (RA + 32'h0000_0100) ^ KEY);
        hbus(2'b10, 0, 0, RA);
        hbus(2'b11, 0, 1, 0);
        wait_rdy;
        hbus(2'b11, 0, 1, 0);
        cmp(host_rdata, RA ^ KEY);
        repeat (20) @(posedge mclk);
        cmp(n_rb, 8);
        cmp(last_len, 3'h1);
        $display("test reads done");
        hbus(2'b10, 1, 0, WA);
        hbus(2'b10, 1, 1, 0);
        cmp(host_rdata, WA);
        post(3);
        repeat (4) @(posedge mclk);
        cmp(n_wb, 0);
        post(1);
        repeat (20) @(posedge mclk);
        cmp(n_wb, 4);
        cmp(last_wdata, 32'hd000_0003);
        post(2);
        repeat (4) @(posedge mclk);
        cmp(n_wb, 4);
        repeat (20) @(posedge mclk);
        cmp(n_wb, 6);
        cmp(last_len, 3'h2);
        slow <= 1'b1;
        post(8);
        cmp(host_ready_n, 1'b1);
        slow <= 1'b0;
        wait_rdy;
        repeat (40) @(posedge mclk);
        cmp(n_wb, 14);
        cmp(last_wdata, 32'hd000_000d);
        hbus(2'b11, 0, 0, 32'hf00d_0001);
        cmp(host_ready_n, 1'b1);
        wait_rdy;
        cmp(n_wb, 15);
        cmp(last_len, 3'h1);
        cmp(last_wdata, 32'hf00d_0001);
        post(2);
        hbus(2'b10, 1, 0, WA);
        @(posedge mclk);
        #1;
        cmp(host_ready_n, 1'b1);
        wait_rdy;
        hbus(2'b10, 1, 0, WA);
        cmp(n_wb, 17);
        $display("test writes done");
        hbus(2'b00, 0, 0, 32'h0000_0002);
        cpu_bus(0, 32'h0000_0004);
        @(posedge mclk);
        arst_n <= 1'b0;
        #1;
        cmp(host_int_n, 1'b1);
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        hbus(2'b00, 0, 1, 0);
        cmp(host_rdata[1], 1'b0);
        $display("test mid-run reset done");
        tally_and_finish;
    end
endmodule // testbench
